// ==== hdl/stop_ctl.sv ====
/*
 Stop-mode sequencer: takes the core's wait-for-interrupt with deep-sleep select,
 walks the entry sequence, holds per-domain controls, and leaves on a wakeup.
 Assumes wakeup sources and core requests are synchronous to clk; pin wakeups are
 synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module stop_ctl (
    input wire logic clk,
    input wire logic rst,
    input wire logic wait_for_interrupt_instr,
    input wire logic deep_sleep_select,
    input wire logic [3:0] mode_select,
    input wire logic ram_32k_select,
    input wire logic converter_continuous,
    input wire logic [1:0] converter_cfg,
    input wire logic rtc_on_osc32k,
    input wire logic periph_irq,
    input wire logic wakeup_unit_irq,
    input wire logic pin_wakeup,
    output logic core_clk_gate,
    output logic core_sleeping,
    output logic isolate,
    output logic low_voltage_detect_en,
    output logic bias_en,
    output logic ram_low_on,
    output logic ram_high_on,
    output logic ram_rest_on,
    output logic regfile_on,
    output logic radio_retain,
    output logic radio_power_gate,
    output logic radio_deep_sleep_en,
    output logic wakeup_unit_en,
    output logic low_power_timer_en,
    output logic rtc_en,
    output logic analog_comparator_en,
    output logic touch_sense_input_en,
    output logic low_power_oscillator_en,
    output logic pmc_analog_en,
    output logic pad_output_hold,
    output logic brown_out_en,
    output logic wakeup_reset,
    output logic req_refused
);
    typedef struct packed {
        stop_ctl_pkg::seq_state_e st;
        stop_ctl_pkg::stop_mode_e mode;
        logic ram32;
        logic rtc32;
        logic refused;
        logic wrst;
        logic pin_s1;
        logic pin_s2;
    } state_s;

    state_s cur_reg;
    state_s cur_next;
    logic step_load;
    logic step_done;
    logic allowed;
    logic wake;
    logic deep_stop;

    // One pacing counter serves every step, since steps never overlap
    step_timer timer_u (
        .clk(clk),
        .rst(rst),
        .load(step_load),
        .done(step_done)
    );

    always_comb begin
        // Minimum stops only in bypass; codes above 7 are not modes
        allowed = !mode_select[3];
        if ((mode_select == 4'(stop_ctl_pkg::MODE_VLEAK_MIN)) ||
            (mode_select == 4'(stop_ctl_pkg::MODE_VLEAK_MIN_NOBOD))) begin
            allowed = (converter_cfg == 2'(stop_ctl_pkg::CONV_BYPASS));
        end
        deep_stop = (cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_MIN) ||
                    (cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_MIN_NOBOD);
        // Minimum stops listen to pins only
        if (deep_stop) begin
            wake = cur_reg.pin_s2;
        end else if (cur_reg.mode == stop_ctl_pkg::MODE_VLP_STOP) begin
            wake = periph_irq || wakeup_unit_irq || cur_reg.pin_s2;
        end else begin
            wake = wakeup_unit_irq || cur_reg.pin_s2;
        end
    end

    always_comb begin
        cur_next = cur_reg;
        step_load = 1'b0;
        cur_next.pin_s1 = pin_wakeup;
        cur_next.pin_s2 = cur_reg.pin_s1;
        cur_next.refused = 1'b0;
        cur_next.wrst = 1'b0;
        case (cur_reg.st)
            stop_ctl_pkg::ST_RUN: begin
                if (wait_for_interrupt_instr && deep_sleep_select) begin
                    if (allowed) begin
                        cur_next.mode = stop_ctl_pkg::stop_mode_e'(mode_select);
                        cur_next.ram32 = ram_32k_select;
                        cur_next.rtc32 = rtc_on_osc32k;
                        cur_next.st = stop_ctl_pkg::ST_GATE_CLK;
                        step_load = 1'b1;
                    end else begin
                        cur_next.refused = 1'b1;
                    end
                end else if (wait_for_interrupt_instr) begin
                    cur_next.st = stop_ctl_pkg::ST_WAIT;
                end
            end
            stop_ctl_pkg::ST_WAIT: begin
                if (periph_irq || wakeup_unit_irq || cur_reg.pin_s2) begin
                    cur_next.st = stop_ctl_pkg::ST_RUN;
                end
            end
            stop_ctl_pkg::ST_GATE_CLK: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_ISOLATE;
                    step_load = 1'b1;
                end
            end
            stop_ctl_pkg::ST_ISOLATE: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_POWER;
                    step_load = 1'b1;
                end
            end
            stop_ctl_pkg::ST_POWER: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_STOPPED;
                end
            end
            stop_ctl_pkg::ST_STOPPED: begin
                if (wake) begin
                    cur_next.st = stop_ctl_pkg::ST_UNPOWER;
                    step_load = 1'b1;
                end
            end
            stop_ctl_pkg::ST_UNPOWER: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_UNISOLATE;
                    step_load = 1'b1;
                end
            end
            stop_ctl_pkg::ST_UNISOLATE: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_UNGATE;
                    step_load = 1'b1;
                end
            end
            stop_ctl_pkg::ST_UNGATE: begin
                if (step_done) begin
                    cur_next.st = stop_ctl_pkg::ST_RUN;
                    // Vleak modes leave through a reset, not an interrupt
                    cur_next.wrst = (cur_reg.mode >= stop_ctl_pkg::MODE_VLEAK_FULL);
                end
            end
            default: begin
                cur_next.st = stop_ctl_pkg::ST_RUN;
            end
        endcase
    end

    // Reset lands in run with every domain powered and nothing isolated
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_reg <= '{st: stop_ctl_pkg::ST_RUN, mode: stop_ctl_pkg::MODE_VLP_STOP,
                         default: 1'b0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    logic clk_off;
    logic iso_on;
    logic pwr_on;
    logic m_very_low_power_stop;
    logic m_leak;
    logic m_vfull;
    logic m_vpart;
    logic m_noram;

    // Power applies only between isolation and release, so domains never drop unisolated
    assign clk_off = (cur_reg.st != stop_ctl_pkg::ST_RUN) &&
                     (cur_reg.st != stop_ctl_pkg::ST_WAIT);
    assign iso_on = clk_off && (cur_reg.st != stop_ctl_pkg::ST_GATE_CLK) &&
                    (cur_reg.st != stop_ctl_pkg::ST_UNGATE);
    assign pwr_on = (cur_reg.st == stop_ctl_pkg::ST_POWER) ||
                    (cur_reg.st == stop_ctl_pkg::ST_STOPPED);
    assign m_very_low_power_stop = pwr_on && (cur_reg.mode == stop_ctl_pkg::MODE_VLP_STOP);
    assign m_leak = pwr_on && ((cur_reg.mode == stop_ctl_pkg::MODE_LEAK_DEEP) ||
                               (cur_reg.mode == stop_ctl_pkg::MODE_LEAK_PART));
    assign m_vfull = pwr_on && (cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_FULL);
    assign m_vpart = pwr_on && (cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_PART);
    assign m_noram = pwr_on && (cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_NORAM);

    assign core_clk_gate = clk_off;
    assign core_sleeping = clk_off || (cur_reg.st == stop_ctl_pkg::ST_WAIT);
    assign isolate = iso_on;
    assign low_voltage_detect_en = !pwr_on;
    assign bias_en = !(m_very_low_power_stop && converter_continuous);
    // Low 16 KB kept in partial modes; upper 16 KB only when 32 KB chosen
    assign ram_low_on = !pwr_on || m_very_low_power_stop || m_leak || m_vfull || m_vpart;
    assign ram_high_on = ram_low_on && !((cur_reg.mode == stop_ctl_pkg::MODE_LEAK_PART ||
                         m_vpart) && pwr_on && !cur_reg.ram32);
    assign ram_rest_on = !pwr_on || m_very_low_power_stop || m_vfull ||
                         (m_leak && cur_reg.mode == stop_ctl_pkg::MODE_LEAK_DEEP);
    assign regfile_on = 1'b1;
    // Radio logic keeps state down to the partial vleak stop and is gated below
    assign radio_retain = m_leak || m_vfull || m_vpart;
    assign radio_deep_sleep_en = !pwr_on || m_very_low_power_stop || m_leak || m_vfull || m_vpart;
    assign radio_power_gate = pwr_on && (cur_reg.mode >= stop_ctl_pkg::MODE_VLEAK_NORAM);
    // In the minimum stops only the pin path stays awake, and in MODE_VLEAK_MIN the brown-out detector
    assign wakeup_unit_en = !pwr_on || !deep_stop;
    assign low_power_timer_en = !pwr_on || !deep_stop;
    assign rtc_en = !pwr_on || !deep_stop;
    assign analog_comparator_en = !pwr_on || !deep_stop;
    assign touch_sense_input_en = !pwr_on || (!deep_stop && !(m_noram && cur_reg.rtc32));
    assign low_power_oscillator_en = !(pwr_on && deep_stop);
    assign pmc_analog_en = !(pwr_on && deep_stop);
    assign pad_output_hold = iso_on;
    assign brown_out_en = !(pwr_on && cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_MIN_NOBOD);
    assign wakeup_reset = cur_reg.wrst;
    assign req_refused = cur_reg.refused;

    // Entry, refusal and exit sequencing
    very_low_power_stop_bias_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_STOPPED && cur_reg.mode == stop_ctl_pkg::MODE_VLP_STOP
         && converter_continuous) |-> !bias_en) else $error("bias on in stop");
    min_bypass_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_RUN && wait_for_interrupt_instr && deep_sleep_select
         && mode_select[3:1] == 3'h3 && converter_cfg != 2'(stop_ctl_pkg::CONV_BYPASS))
        |=> cur_reg.st == stop_ctl_pkg::ST_RUN) else $error("minimum stop without bypass");
    refuse_stay_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_RUN && wait_for_interrupt_instr && deep_sleep_select
         && !allowed) |=> cur_reg.st == stop_ctl_pkg::ST_RUN && req_refused)
        else $error("refused request moved state");
    entry_order_a: assert property (@(posedge clk) disable iff (rst)
        $rose(isolate) |-> $past(core_clk_gate) && !pwr_on) else $error("isolate early");
    exit_order_a: assert property (@(posedge clk) disable iff (rst)
        $fell(isolate) |-> core_clk_gate && !pwr_on) else $error("clock ungated early");
    radio_gate_a: assert property (@(posedge clk) disable iff (rst)
        radio_power_gate |-> !radio_retain && isolate) else $error("radio gated badly");
    nobod_off_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_STOPPED && cur_reg.mode ==
         stop_ctl_pkg::MODE_VLEAK_MIN_NOBOD) |-> !brown_out_en && !low_power_oscillator_en)
        else $error("brown-out left on");
    min_pin_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_STOPPED && deep_stop && !cur_reg.pin_s2)
        |=> cur_reg.st == stop_ctl_pkg::ST_STOPPED) else $error("non-pin wake");
    wake_reset_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_STOPPED && wake && cur_reg.mode >=
         stop_ctl_pkg::MODE_VLEAK_FULL) |-> ##[20:40] wakeup_reset)
        else $error("no wakeup reset");
    irq_exit_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_UNGATE && step_done && cur_reg.mode <
         stop_ctl_pkg::MODE_VLEAK_FULL) |=> !wakeup_reset)
        else $error("reset on interrupt exit");
    wfi_wait_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_RUN && wait_for_interrupt_instr && !deep_sleep_select)
        |=> cur_reg.st == stop_ctl_pkg::ST_WAIT) else $error("wait not entered");
    wait_exit_a: assert property (@(posedge clk) disable iff (rst)
        (cur_reg.st == stop_ctl_pkg::ST_WAIT && periph_irq)
        |=> !core_sleeping) else $error("wait not left");

    // Mode contents, checked once the power controls apply
    very_low_power_stop_periph_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && cur_reg.mode == stop_ctl_pkg::MODE_VLP_STOP) |-> !low_voltage_detect_en
        && low_power_timer_en && rtc_en && analog_comparator_en && touch_sense_input_en)
        else $error("peripheral off in very low power stop");
    part_ram_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && (cur_reg.mode == stop_ctl_pkg::MODE_LEAK_PART ||
         cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_PART)) |-> ram_low_on && !ram_rest_on
        && ram_high_on == cur_reg.ram32) else $error("partial RAM set wrong");
    radio_keep_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && cur_reg.mode != stop_ctl_pkg::MODE_VLP_STOP &&
         cur_reg.mode < stop_ctl_pkg::MODE_VLEAK_NORAM) |-> radio_retain && radio_deep_sleep_en
        && !radio_power_gate) else $error("radio logic not retained");
    sram_off_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && cur_reg.mode >= stop_ctl_pkg::MODE_VLEAK_NORAM) |-> regfile_on
        && !ram_low_on && !ram_high_on && !ram_rest_on) else $error("SRAM left powered");
    noram_touch_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_NORAM) |-> wakeup_unit_en
        && touch_sense_input_en == !cur_reg.rtc32) else $error("touch sense set wrong");
    min_analog_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && deep_stop) |-> !pmc_analog_en && pad_output_hold
        && !low_power_oscillator_en && !wakeup_unit_en) else $error("minimum stop left on");
    bod_on_a: assert property (@(posedge clk) disable iff (rst)
        (pwr_on && cur_reg.mode == stop_ctl_pkg::MODE_VLEAK_MIN) |-> brown_out_en)
        else $error("brown-out off in minimum stop");

    // Main flows: stop, reset exit, refusal, wait, pin wake
    cv_stop: cover property (@(posedge clk) cur_reg.st == stop_ctl_pkg::ST_STOPPED);
    cv_reset: cover property (@(posedge clk) wakeup_reset);
    cv_refuse: cover property (@(posedge clk) req_refused);
    cv_wait: cover property (@(posedge clk) cur_reg.st == stop_ctl_pkg::ST_WAIT);
    cv_pin_wake: cover property (@(posedge clk)
        cur_reg.st == stop_ctl_pkg::ST_STOPPED && deep_stop && wake);
endmodule
`default_nettype wire

// ==== hdl/stop_ctl_pkg.sv ====
/*
 Constants, mode codes and sequencing counts for the low-leakage stop controller.
 Assumes a single 250 MHz clock and an asynchronous active-high reset.
*/
// Contract
// - Very low power stop: core static, detection off
// - Continuous converter in that stop disables biasing
// - Deep leak stop retains everything, wakeup interrupt
// - Partial leak stop keeps 16 or 32 KB
// - Leak and upper vleak stops retain radio logic
// - Full RAM vleak stop retains all, wakeup reset
// - Partial vleak stop keeps selected RAM, reset exit
// - Lowest vleak stops drop SRAM, keep register file
// - Lowest vleak stops power-gate radio logic
// - No-RAM stop peripheral set depends on clock
// - Minimum stop only with converter in bypass
// - Minimum stop: analog off, pads held, pins wake
// - Minimum stop offers brown-out on or off
// - Brown-out off variant disables the detector
// - Wait instruction plus deep-sleep select picks stop
package stop_ctl_pkg;
    typedef enum logic [3:0] {
        MODE_VLP_STOP = 4'h0,
        MODE_LEAK_DEEP = 4'h1,
        MODE_LEAK_PART = 4'h2,
        MODE_VLEAK_FULL = 4'h3,
        MODE_VLEAK_PART = 4'h4,
        MODE_VLEAK_NORAM = 4'h5,
        MODE_VLEAK_MIN = 4'h6,
        MODE_VLEAK_MIN_NOBOD = 4'h7
    } stop_mode_e;

    typedef enum logic [1:0] {
        CONV_BUCK = 2'h0,
        CONV_BOOST = 2'h1,
        CONV_BYPASS = 2'h2
    } conv_cfg_e;

    typedef enum logic [3:0] {
        ST_RUN = 4'h0,
        ST_WAIT = 4'h1,
        ST_GATE_CLK = 4'h2,
        ST_ISOLATE = 4'h3,
        ST_POWER = 4'h4,
        ST_STOPPED = 4'h5,
        ST_UNPOWER = 4'h6,
        ST_UNISOLATE = 4'h7,
        ST_UNGATE = 4'h8
    } seq_state_e;

    // Settle time for each sequencing step
    localparam int STEP_NS = 40;
    localparam int CLK_NS = 4;
    localparam logic [3:0] STEP_CYCLES = 4'((STEP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STEP_RESET = 4'h0;
endpackage

// ==== hdl/step_timer.sv ====
/*
 Down-counter that paces one sequencing step.
 Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module step_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    output logic done
);
    logic [3:0] cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= stop_ctl_pkg::STEP_RESET;
        end else if (load) begin
            cnt_reg <= stop_ctl_pkg::STEP_CYCLES;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    // Plain count compare: load is raised from done, so it must not feed back
    assign done = (cnt_reg == 4'h0);
endmodule
`default_nettype wire

// ==== verification/core_model.sv ====
/*
 Core and wakeup-source model facing the stop controller.
 Assumes the bench calls its tasks and that inputs change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk,
    output var logic wait_for_interrupt_instr,
    output var logic deep_sleep_select,
    output var logic [3:0] mode_select,
    output var logic ram_32k_select,
    output var logic converter_continuous,
    output var logic [1:0] converter_cfg,
    output var logic rtc_on_osc32k,
    output var logic periph_irq,
    output var logic wakeup_unit_irq,
    output var logic pin_wakeup
);
    initial begin
        {wait_for_interrupt_instr, deep_sleep_select, mode_select} = '0;
        {ram_32k_select, converter_continuous, converter_cfg, rtc_on_osc32k} = '0;
        {periph_irq, wakeup_unit_irq, pin_wakeup} = '0;
    end
    // Settings are only changed while running, never mid-sequence
    task automatic set_cfg(input logic c, input logic [1:0] f, input logic r, input logic o);
        @(negedge clk);
        {converter_continuous, converter_cfg, ram_32k_select, rtc_on_osc32k} = {c, f, r, o};
    endtask
    // One-cycle wait instruction; deep-sleep level stays while asleep
    task automatic request(input logic d, input logic [3:0] m);
        @(negedge clk);
        deep_sleep_select = d;
        mode_select = m;
        wait_for_interrupt_instr = 1'b1;
        @(negedge clk);
        wait_for_interrupt_instr = 1'b0;
    endtask
    // Sources are levels, dropped once the core has serviced them
    task automatic set_wake(input logic [2:0] src);
        @(negedge clk);
        {pin_wakeup, wakeup_unit_irq, periph_irq} = src;
    endtask
endmodule
`default_nettype wire

// ==== verification/stop_ctl_tb.sv ====
/*
 Self-checking bench for the stop-mode sequencer.
 Assumes the core model drives all requests and wakeup sources.
*/
`timescale 1ns/1ps
`default_nettype none
module stop_ctl_tb;
    logic clk, rst, wait_for_interrupt_instr, deep_sleep_select, ram_32k_select;
    logic converter_continuous, rtc_on_osc32k, periph_irq, wakeup_unit_irq, pin_wakeup;
    logic [3:0] mode_select;
    logic [1:0] converter_cfg;
    logic core_clk_gate, core_sleeping, isolate, low_voltage_detect_en, bias_en;
    logic ram_low_on, ram_high_on, ram_rest_on, regfile_on, radio_retain, radio_power_gate;
    logic radio_deep_sleep_en, wakeup_unit_en, low_power_timer_en, rtc_en;
    logic analog_comparator_en, touch_sense_input_en, low_power_oscillator_en;
    logic pmc_analog_en, pad_output_hold, brown_out_en, wakeup_reset, req_refused;
    int error_cnt = 0;
    int checks_done = 0;
    int t_gate, t_iso, t_pow, n_pulse;
    wire logic [3:0] mem = {ram_low_on, ram_high_on, ram_rest_on, regfile_on};
    wire logic [1:0] rad = {radio_retain, radio_power_gate};
    wire logic [4:0] per = {wakeup_unit_en, low_power_timer_en, rtc_en,
        analog_comparator_en, touch_sense_input_en};
    wire logic [3:0] ana = {pmc_analog_en, pad_output_hold, low_power_oscillator_en,
        brown_out_en};
    stop_ctl dut_u (.*);
    core_model core_u (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Power controls apply 22 cycles after the request is taken; checks follow
    task automatic enter(input logic [3:0] m);
        {t_gate, t_iso, t_pow} = '0;
        core_u.request(1'b1, m);
        for (int i = 1; i < 30; i++) begin
            @(negedge clk);
            if (core_clk_gate === 1'b1 && t_gate == 0) t_gate = i;
            if (isolate === 1'b1 && t_iso == 0) t_iso = i;
            if (ram_rest_on === 1'b0 && t_pow == 0) t_pow = i;
        end
    endtask
    task automatic leave(input logic [2:0] src, input logic exp_rst);
        n_pulse = 0;
        core_u.set_wake(src);
        for (int i = 0; i < 60 && core_clk_gate !== 1'b0; i++) begin
            @(negedge clk);
            if (wakeup_reset === 1'b1) n_pulse++;
        end
        chk(8'(core_clk_gate), 8'h0);
        chk(8'(isolate), 8'h0);
        chk(8'(n_pulse), 8'(exp_rst));
        core_u.set_wake(3'h0);
        repeat (3) @(negedge clk);
    endtask
    // Wrong source for the mode: the core must stay asleep
    task automatic no_wake(input logic [2:0] src);
        core_u.set_wake(src);
        repeat (40) @(negedge clk);
        chk(8'(core_clk_gate), 8'h1);
        core_u.set_wake(3'h0);
    endtask
    task automatic t_very_low_power_stop();
        core_u.set_cfg(1'b1, 2'h0, 1'b0, 1'b0);
        enter(4'h0);
        chk(8'(bias_en), 8'h0);
        chk(8'(low_voltage_detect_en), 8'h0);
        chk(8'(per[3:0]), 8'hF);
        leave(3'h1, 1'b0);
    endtask
    task automatic t_leak();
        core_u.set_cfg(1'b0, 2'h0, 1'b0, 1'b0);
        enter(4'h1);
        chk(8'(mem), 8'hF);
        chk(8'(rad), 8'h2);
        chk(8'(radio_deep_sleep_en), 8'h1);
        chk(8'(per), 8'h1F);
        no_wake(3'h1);
        leave(3'h2, 1'b0);
        enter(4'h2);
        chk(8'(t_gate > 0 && t_gate < t_iso && t_iso < t_pow), 8'h1);
        chk(8'(t_gate), 8'h1);
        chk(8'(t_iso), 8'(int'(stop_ctl_pkg::STEP_CYCLES) + 1));
        chk(8'(t_pow), 8'(2 * (int'(stop_ctl_pkg::STEP_CYCLES) + 1)));
        chk(8'(mem), 8'h9);
        chk(8'(rad), 8'h2);
        leave(3'h2, 1'b0);
        core_u.set_cfg(1'b0, 2'h0, 1'b1, 1'b0);
        enter(4'h2);
        chk(8'(mem), 8'hD);
        leave(3'h2, 1'b0);
    endtask
    task automatic t_vleak();
        enter(4'h3);
        chk(8'(mem), 8'hF);
        chk(8'(rad), 8'h2);
        chk(8'(per), 8'h1F);
        leave(3'h2, 1'b1);
        enter(4'h4);
        chk(8'(mem), 8'hD);
        chk(8'(rad), 8'h2);
        leave(3'h2, 1'b1);
        core_u.set_cfg(1'b0, 2'h0, 1'b0, 1'b1);
        enter(4'h5);
        chk(8'(mem), 8'h1);
        chk(8'(rad), 8'h1);
        chk(8'(radio_deep_sleep_en), 8'h0);
        chk(8'(per), 8'h1E);
        leave(3'h2, 1'b1);
        core_u.set_cfg(1'b0, 2'h0, 1'b0, 1'b0);
        enter(4'h5);
        chk(8'(per), 8'h1F);
        leave(3'h2, 1'b1);
    endtask
    // Minimum modes are refused outside bypass, as is unknown code 8
    task automatic t_refuse();
        for (int k = 0; k < 5; k++) begin
            core_u.set_cfg(1'b0, 2'(k % 2), 1'b0, 1'b0);
            core_u.request(1'b1, (k == 4) ? 4'h8 : 4'(6 + k / 2));
            n_pulse = int'(req_refused === 1'b1);
            repeat (2) @(negedge clk) n_pulse += int'(req_refused === 1'b1);
            chk(8'(n_pulse), 8'h1);
            chk(8'(core_clk_gate), 8'h0);
        end
    endtask
    task automatic t_minimum();
        core_u.set_cfg(1'b0, 2'h2, 1'b0, 1'b0);
        enter(4'h6);
        chk(8'(ana), 8'h5);
        chk(8'(mem), 8'h1);
        chk(8'(rad), 8'h1);
        no_wake(3'h2);
        leave(3'h4, 1'b1);
        enter(4'h7);
        chk(8'(ana), 8'h4);
        no_wake(3'h2);
        leave(3'h4, 1'b1);
    endtask
    task automatic t_wait();
        core_u.request(1'b0, 4'h3);
        repeat (26) @(negedge clk);
        chk(8'(isolate), 8'h0);
        chk(8'(core_sleeping), 8'h1);
        leave(3'h1, 1'b0);
        chk(8'(core_sleeping), 8'h0);
    endtask
    // Whole run is near 935 cycles; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk(8'({core_clk_gate, isolate, wakeup_reset, req_refused}), 8'h0);
        chk(8'(ana), 8'hB);
        t_very_low_power_stop();
        t_leak();
        t_vleak();
        t_refuse();
        t_minimum();
        t_wait();
        summarize();
    end
endmodule
`default_nettype wire
